// ---- include/alert_mask_pkg.sv ----
`default_nettype none
package alert_mask_pkg;

  localparam logic [7:0] MASK_CMD = 8'h1b;
  localparam logic [7:0] SEL_TEMP = 8'h7d;
  localparam logic [7:0] SEL_COMM = 8'h7e;
  localparam logic [7:0] SEL_OTHER = 8'h7f;
  localparam logic [7:0] SEL_VENDOR = 8'h80;
  localparam logic [7:0] PHASE_ALL = 8'hff;

  // Writable bit sets per group
  localparam logic [7:0] TEMP_RW = 8'hc0;
  localparam logic [7:0] COMM_RW = 8'hf2;
  localparam logic [7:0] OTHER_RW = 8'h00;
  localparam logic [7:0] VENDOR_RW = 8'hce;
  localparam logic [7:0] OTHER_FIXED = 8'h01;

  // Field positions
  localparam int OVERTEMP_FAULT_BIT = 7;
  localparam int OVERTEMP_WARN_BIT = 6;
  localparam int SELF_CHECK_BIT = 6;
  localparam int SYNC_FAULT_BIT = 1;
  localparam int FIRST_ALERTER_BIT = 0;
  localparam int BAD_COMMAND_BIT = 7;
  localparam int BAD_DATA_BIT = 6;
  localparam int PACKET_CHECK_BIT = 5;
  localparam int MEMORY_FAULT_BIT = 4;
  localparam int PROCESSOR_FAULT_BIT = 3;
  localparam int OTHER_COMM_BIT = 1;
  localparam int POWER_ON_EVENT_BIT = 7;
  localparam int RESET_PIN_EVENT_BIT = 3;
  localparam int BACKCHANNEL_ERROR_BIT = 2;

  // Block answer is one byte long
  localparam logic [7:0] BLOCK_COUNT = 8'h01;

  // One host request as handed up by the bus engine
  typedef struct packed {
    logic wr_valid;
    logic rd_valid;
    logic [7:0] cmd;
    logic [7:0] sel;
    logic [7:0] data;
  } mask_req_t;

  typedef struct packed {
    logic valid;
    logic ack;
    logic [7:0] count;
    logic [7:0] data;
  } mask_rsp_t;

  typedef struct packed {
    logic [7:0] temp;
    logic [7:0] comm;
    logic [7:0] vendor;
  } mask_set_t;

  typedef struct packed {
    logic [7:0] temp;
    logic [7:0] comm;
    logic [7:0] other;
    logic [7:0] vendor;
  } status_set_t;

endpackage
`default_nettype wire

// ---- rtl/alert_gate.sv ----
`timescale 1ns/100ps
`default_nettype none
module alert_gate (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire alert_mask_pkg::status_set_t status,
  input wire alert_mask_pkg::mask_set_t masks,
  output logic alert_req
);

  typedef struct packed {
    logic req;
  } gate_state_t;

  gate_state_t s_q, s_d;
  logic [31:0] hits;
  logic [31:0] mask_word;

  // Other group is always masked: its only source cannot alert alone
  assign mask_word = {masks.temp, masks.comm, alert_mask_pkg::OTHER_FIXED | 8'hfe, masks.vendor};

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      assign hits[i] = status[i] & ~mask_word[i];
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    s_d.req = |hits;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign alert_req = s_q.req;

  unmasked_drives_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (|(status & ~mask_word)) |=> alert_req)
    else $error("Unmasked status did not raise alert");
  masked_silent_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((status & ~mask_word) == 32'h0) |=> !alert_req)
    else $error("Masked status raised alert");
  other_blocked_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (status.temp == 8'h0 && status.comm == 8'h0 && status.vendor == 8'h0) |=> !alert_req)
    else $error("Other group reached alert");

endmodule
`default_nettype wire

// ---- rtl/alert_mask_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Command 1Bh plus selector picks mask
// - Process call reads one-byte mask block
// - Mask bit 0 passes, 1 blocks alert
// - Temperature: bits 7,6 writable, rest zero
// - Communication: bits 7..4,1 writable, others zero
// - Other group: bit 0 fixed one
// - Vendor: bits 7,6,3,2,1 writable
// - Clear self-check mask risks power-up alert
// - Clear sync mask risks brief alert
module alert_mask_bank (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire alert_mask_pkg::mask_req_t req,
  input wire logic [7:0] phase,
  input wire logic nvm_valid,
  input wire alert_mask_pkg::mask_set_t nvm_masks,
  input wire alert_mask_pkg::status_set_t status,
  output alert_mask_pkg::mask_rsp_t rsp,
  output alert_mask_pkg::mask_set_t masks,
  output logic loaded,
  output logic alert_req
);

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN = 2'b01
  } bank_mode_t;

  typedef struct packed {
    bank_mode_t mode;
    alert_mask_pkg::mask_set_t m;
    alert_mask_pkg::mask_rsp_t r;
  } bank_state_t;

  bank_state_t s_q, s_d;
  logic hit_cmd;
  logic phase_ok;
  logic [7:0] rd_byte;
  logic sel_known;
  logic take_wr;
  logic take_rd;
  logic phased_sel;
  logic [7:0] temp_view;
  logic [7:0] comm_view;
  logic [7:0] vendor_view;
  logic overtemp_fault_mask;
  logic overtemp_warn_mask;
  logic bad_command_mask;
  logic bad_data_mask;
  logic packet_check_mask;
  logic memory_fault_mask;
  logic processor_fault_mask;
  logic other_comm_fault_mask;
  logic power_on_event_mask;
  logic self_check_mask;
  logic reset_pin_event_mask;
  logic backchannel_error_mask;
  logic sync_fault_mask;

  assign hit_cmd = req.cmd == alert_mask_pkg::MASK_CMD;

  // Requests only count once storage has restored the masks; write wins a tie
  assign take_wr = s_q.mode == ST_RUN && req.wr_valid && hit_cmd;
  assign take_rd = s_q.mode == ST_RUN && req.rd_valid && !req.wr_valid && hit_cmd;
  assign phased_sel = req.sel == alert_mask_pkg::SEL_TEMP || req.sel == alert_mask_pkg::SEL_COMM;

  // Phased groups only accept the all-phases selection
  always_comb begin
    phase_ok = 1'b1;
    if (phased_sel) begin
      phase_ok = phase == alert_mask_pkg::PHASE_ALL;
    end
  end

  always_comb begin
    sel_known = 1'b1;
    rd_byte = 8'h00;
    case (req.sel)
      alert_mask_pkg::SEL_TEMP: rd_byte = s_q.m.temp & alert_mask_pkg::TEMP_RW;
      alert_mask_pkg::SEL_COMM: rd_byte = s_q.m.comm & alert_mask_pkg::COMM_RW;
      alert_mask_pkg::SEL_OTHER: rd_byte = alert_mask_pkg::OTHER_FIXED;
      alert_mask_pkg::SEL_VENDOR: rd_byte = s_q.m.vendor & alert_mask_pkg::VENDOR_RW;
      default: sel_known = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.r = '0;
    case (s_q.mode)
      ST_LOAD: begin
        // Hold off the host until storage has restored the masks
        if (nvm_valid) begin
          s_d.m.temp = nvm_masks.temp & alert_mask_pkg::TEMP_RW;
          s_d.m.comm = nvm_masks.comm & alert_mask_pkg::COMM_RW;
          s_d.m.vendor = nvm_masks.vendor & alert_mask_pkg::VENDOR_RW;
          s_d.mode = ST_RUN;
        end
      end
      ST_RUN: begin
        if (take_wr) begin
          s_d.r.valid = 1'b1;
          s_d.r.ack = sel_known && phase_ok;
          if (phase_ok) begin
            case (req.sel)
              alert_mask_pkg::SEL_TEMP: s_d.m.temp = req.data & alert_mask_pkg::TEMP_RW;
              alert_mask_pkg::SEL_COMM: s_d.m.comm = req.data & alert_mask_pkg::COMM_RW;
              alert_mask_pkg::SEL_VENDOR: s_d.m.vendor = req.data & alert_mask_pkg::VENDOR_RW;
              default: s_d.m = s_q.m;
            endcase
          end
        end else if (take_rd) begin
          s_d.r.valid = 1'b1;
          s_d.r.ack = sel_known && phase_ok;
          s_d.r.count = alert_mask_pkg::BLOCK_COUNT;
          s_d.r.data = phase_ok ? rd_byte : 8'h00;
        end
      end
      default: s_d.mode = ST_LOAD;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp = s_q.r;
  assign masks = s_q.m;
  assign loaded = s_q.mode == ST_RUN;

  // Named fields, laid out apart from the masking constants so the checks cross them
  assign overtemp_fault_mask = s_q.m.temp[alert_mask_pkg::OVERTEMP_FAULT_BIT];
  assign overtemp_warn_mask = s_q.m.temp[alert_mask_pkg::OVERTEMP_WARN_BIT];
  assign bad_command_mask = s_q.m.comm[alert_mask_pkg::BAD_COMMAND_BIT];
  assign bad_data_mask = s_q.m.comm[alert_mask_pkg::BAD_DATA_BIT];
  assign packet_check_mask = s_q.m.comm[alert_mask_pkg::PACKET_CHECK_BIT];
  assign memory_fault_mask = s_q.m.comm[alert_mask_pkg::MEMORY_FAULT_BIT];
  assign processor_fault_mask = s_q.m.comm[alert_mask_pkg::PROCESSOR_FAULT_BIT];
  assign other_comm_fault_mask = s_q.m.comm[alert_mask_pkg::OTHER_COMM_BIT];
  assign power_on_event_mask = s_q.m.vendor[alert_mask_pkg::POWER_ON_EVENT_BIT];
  assign self_check_mask = s_q.m.vendor[alert_mask_pkg::SELF_CHECK_BIT];
  assign reset_pin_event_mask = s_q.m.vendor[alert_mask_pkg::RESET_PIN_EVENT_BIT];
  assign backchannel_error_mask = s_q.m.vendor[alert_mask_pkg::BACKCHANNEL_ERROR_BIT];
  assign sync_fault_mask = s_q.m.vendor[alert_mask_pkg::SYNC_FAULT_BIT];
  assign temp_view = {overtemp_fault_mask, overtemp_warn_mask, 6'h00};
  assign comm_view = {bad_command_mask, bad_data_mask, packet_check_mask, memory_fault_mask, 2'b00,
    other_comm_fault_mask, 1'b0};
  assign vendor_view = {power_on_event_mask, self_check_mask, 2'b00, reset_pin_event_mask,
    backchannel_error_mask, sync_fault_mask, 1'b0};

  // Self-check and sync bits pass straight into gating; clearing them
  // lets power-up or stack-enable glitches through by design
  alert_gate u_gate (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .status(status),
    .masks(s_q.m),
    .alert_req(alert_req)
  );

  temp_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (loaded && req.wr_valid && hit_cmd && req.sel == alert_mask_pkg::SEL_TEMP && phase == 8'hff)
    |=> masks.temp == ($past(req.data) & 8'hc0))
    else $error("Temperature mask write wrong");
  comm_reserved_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (masks.comm & 8'h0d) == 8'h00)
    else $error("Communication reserved bits set");
  vendor_reserved_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (masks.vendor & 8'h31) == 8'h00)
    else $error("Vendor reserved bits set");
  other_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (loaded && req.rd_valid && !req.wr_valid && hit_cmd && req.sel == alert_mask_pkg::SEL_OTHER)
    |=> rsp.valid && rsp.data == 8'h01 && rsp.count == 8'h01)
    else $error("Other mask read not one");
  read_back_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (loaded && req.rd_valid && !req.wr_valid && hit_cmd && req.sel == alert_mask_pkg::SEL_VENDOR)
    |=> rsp.data == masks.vendor)
    else $error("Vendor mask readback mismatch");
  phase_guard_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_wr && req.sel == alert_mask_pkg::SEL_COMM && phase != 8'hff)
    |=> $stable(masks.comm))
    else $error("Per-phase write reached comm mask");
  foreign_cmd_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((req.wr_valid || req.rd_valid) && !hit_cmd) |=> !rsp.valid)
    else $error("Foreign command answered");
  load_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!loaded && nvm_valid) |=> loaded && masks.comm == ($past(nvm_masks.comm) & 8'hf2))
    else $error("Storage load wrong");
  write_answer_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take_wr |=> rsp.valid && rsp.count == 8'h00 && rsp.data == 8'h00)
    else $error("Write answer malformed");
  read_count_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take_rd |=> rsp.valid && rsp.count == alert_mask_pkg::BLOCK_COUNT)
    else $error("Read block count wrong");
  idle_quiet_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(take_wr || take_rd) |=> !rsp.valid)
    else $error("Answer without request");
  load_silent_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !loaded |=> !rsp.valid)
    else $error("Answer before storage load");
  comm_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_wr && req.sel == alert_mask_pkg::SEL_COMM && phase == 8'hff)
    |=> masks.comm == ($past(req.data) & 8'hf2))
    else $error("Communication mask write wrong");
  vendor_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_wr && req.sel == alert_mask_pkg::SEL_VENDOR)
    |=> masks.vendor == ($past(req.data) & 8'hce))
    else $error("Vendor mask write wrong");
  other_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_wr && req.sel == alert_mask_pkg::SEL_OTHER) |=> rsp.ack && $stable(masks))
    else $error("Other group write not ignored");
  unknown_sel_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((take_wr || take_rd) && !sel_known)
    |=> !rsp.ack && rsp.data == 8'h00 && $stable(masks))
    else $error("Unknown selector accepted");
  phase_refuse_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((take_wr || take_rd) && phased_sel && phase != 8'hff)
    |=> !rsp.ack && rsp.data == 8'h00 && $stable(masks))
    else $error("Per-phase access accepted");
  temp_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_rd && req.sel == alert_mask_pkg::SEL_TEMP && phase == 8'hff)
    |=> rsp.ack && rsp.data == masks.temp)
    else $error("Temperature mask readback wrong");
  comm_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_rd && req.sel == alert_mask_pkg::SEL_COMM && phase == 8'hff)
    |=> rsp.ack && rsp.data == masks.comm)
    else $error("Communication mask readback wrong");
  vendor_any_phase_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_rd && req.sel == alert_mask_pkg::SEL_VENDOR && phase != 8'hff)
    |=> rsp.ack && rsp.data == masks.vendor)
    else $error("Vendor mask refused at a single phase");
  read_ack_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_rd && sel_known && !(phased_sel && phase != 8'hff))
    |=> rsp.ack)
    else $error("Valid read not acknowledged");
  write_ack_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_wr && sel_known && !(phased_sel && phase != 8'hff))
    |=> rsp.ack)
    else $error("Valid write not acknowledged");
  hold_masks_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (loaded && !take_wr) |=> $stable(masks))
    else $error("Masks changed without write");
  loaded_sticky_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    loaded |=> loaded)
    else $error("Loaded flag dropped");
  load_masks_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!loaded && nvm_valid) |=> masks.temp == ($past(nvm_masks.temp) & 8'hc0)
      && masks.vendor == ($past(nvm_masks.vendor) & 8'hce))
    else $error("Storage load wrong for temperature or vendor");
  load_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !loaded |-> masks == '0)
    else $error("Masks set before storage load");
  temp_map_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    masks.temp == temp_view)
    else $error("Temperature reserved bits set");
  comm_map_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    masks.comm == comm_view)
    else $error("Communication field map broken");
  vendor_map_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    masks.vendor == vendor_view)
    else $error("Vendor field map broken");
  processor_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !processor_fault_mask)
    else $error("Processor fault mask bit set");
  self_check_pass_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!self_check_mask && status.vendor[alert_mask_pkg::SELF_CHECK_BIT])
    |=> alert_req)
    else $error("Unmasked self-check did not alert");
  sync_pass_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!sync_fault_mask && status.vendor[alert_mask_pkg::SYNC_FAULT_BIT])
    |=> alert_req)
    else $error("Unmasked sync fault did not alert");
  overtemp_pass_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!overtemp_fault_mask && status.temp[alert_mask_pkg::OVERTEMP_FAULT_BIT])
    |=> alert_req)
    else $error("Unmasked overtemperature fault did not alert");
  warn_pass_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!overtemp_warn_mask && status.temp[alert_mask_pkg::OVERTEMP_WARN_BIT])
    |=> alert_req)
    else $error("Unmasked overtemperature warning did not alert");
  other_read_ack_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take_rd && req.sel == alert_mask_pkg::SEL_OTHER)
    |=> rsp.ack && rsp.data == alert_mask_pkg::OTHER_FIXED)
    else $error("Other mask read refused");

  // Mask bit b gates the status bit at the same place; the other group is skipped
  genvar b;
  generate
    for (b = 0; b < 24; b++) begin : g_pass
      bit_pass_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!masks[b] && status[b < 8 ? b : b + 8]) |=> alert_req)
        else $error("Unmasked status bit did not raise alert");
    end
  endgenerate

endmodule
`default_nettype wire

// ---- bench/pmbus_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmbus_host_model (
  input wire logic ref_clk,
  output alert_mask_pkg::mask_req_t req,
  output logic [7:0] phase
);
  initial begin
    req = '0;
    phase = 8'hff;
  end
  // Idle bus shows inverted bytes so a stale copy never passes
  task automatic send(input logic wr, input logic [7:0] sel, dat, ph, cmd);
    @(posedge ref_clk);
    #1;
    phase = ph;
    req = '{wr, !wr, cmd, sel, dat};
    @(posedge ref_clk);
    #1;
    req = '{1'b0, 1'b0, ~cmd, ~sel, ~dat};
  endtask
endmodule
`default_nettype wire

// ---- bench/alert_mask_bank_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module alert_mask_bank_test;
  logic ref_clk = 0;
  logic arst_n = 0;
  logic nvm_valid = 0;
  logic live = 0;
  alert_mask_pkg::mask_set_t nvm_masks = '0;
  alert_mask_pkg::status_set_t status = '0;
  alert_mask_pkg::mask_req_t req;
  alert_mask_pkg::mask_rsp_t rsp;
  alert_mask_pkg::mask_set_t masks;
  alert_mask_pkg::mask_set_t m;
  alert_mask_pkg::mask_rsp_t q[$];
  logic [7:0] phase;
  logic loaded;
  logic alert_req;
  logic [7:0] d;
  logic [7:0] ex[4];
  logic [7:0] rw[4] = '{alert_mask_pkg::TEMP_RW, alert_mask_pkg::COMM_RW, alert_mask_pkg::OTHER_RW,
    alert_mask_pkg::VENDOR_RW};
  logic [7:0] sels[4] = '{8'h7d, 8'h7e, 8'h7f, 8'h80};
  int failures = 0;
  int n_checks = 0;
  int i;
  always #10 ref_clk = ~ref_clk;
  alert_mask_bank u_alert_mask_bank (.ref_clk(ref_clk), .arst_n(arst_n), .req(req), .phase(phase),
    .nvm_valid(nvm_valid), .nvm_masks(nvm_masks), .status(status), .rsp(rsp), .masks(masks),
    .loaded(loaded), .alert_req(alert_req));
  pmbus_host_model u_pmbus_host_model (.ref_clk(ref_clk), .req(req), .phase(phase));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic op(input logic wr, input logic [7:0] sel, dat, ph, input logic ack, input logic [7:0] rd,
                    input logic [7:0] cmd = alert_mask_pkg::MASK_CMD);
    if (cmd == alert_mask_pkg::MASK_CMD && live)
      q.push_back('{1'b1, ack, wr ? 8'h00 : 8'h01, wr ? 8'h00 : rd});
    u_pmbus_host_model.send(wr, sel, dat, ph, cmd);
  endtask
  task automatic settle();
    int k = 0;
    while (q.size() != 0 && k < 20) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 20) begin
      failures++;
      wrap_up();
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // Unexpected answers land on an empty queue and fail
  always @(posedge ref_clk) begin
    if (rsp.valid === 1'b1) begin
      if (q.size() == 0)
        chk(rsp, '0);
      else
        chk(rsp, q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h6ba777ac));
    nvm_masks = 24'($urandom()) & {rw[0], rw[1], rw[3]};
    repeat (6) @(posedge ref_clk);
    chk({masks, loaded}, '0);
    #1;
    arst_n = 1;
    op(1, sels[0], 8'hff, 8'hff, 1, 0);
    nvm_valid = 1;
    i = 0;
    while (loaded !== 1'b1 && i < 20) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    if (i == 20) begin
      failures++;
      wrap_up();
    end
    chk(masks, nvm_masks);
    $display("test load done");
    live = 1;
    for (i = 0; i < 8; i++) begin
      d = i < 4 ? 8'hff : 8'($urandom());
      ex[i % 4] = (d & rw[i % 4]) | (i % 4 == 2 ? alert_mask_pkg::OTHER_FIXED : 8'h00);
      op(1, sels[i % 4], d, 8'hff, 1, 0);
      op(0, sels[i % 4], 0, 8'hff, 1, ex[i % 4]);
    end
    settle();
    $display("test groups done");
    op(1, sels[0], 8'h00, 8'h03, 0, 0);
    op(0, sels[1], 0, 8'h03, 0, 0);
    op(1, 8'h7a, 8'h00, 8'hff, 0, 0);
    op(1, sels[0], 8'h00, 8'hff, 0, 0, 8'h1c);
    op(0, sels[0], 0, 8'hff, 1, ex[0]);
    op(0, sels[3], 0, 8'h03, 1, ex[3]);
    settle();
    $display("test refusals done");
    for (i = 0; i < 12; i++) begin
      m = i == 0 ? '0 : 24'($urandom()) & {rw[0], rw[1], rw[3]};
      if (i == 1)
        m = {rw[0], rw[1], rw[3]};
      op(1, sels[0], m.temp, 8'hff, 1, 0);
      op(1, sels[1], m.comm, 8'hff, 1, 0);
      op(1, sels[3], m.vendor, 8'hff, 1, 0);
      status = i < 2 ? 32'h42 : 32'($urandom()) & {rw[0], rw[1], 8'hff, rw[3]};
      settle();
      chk(masks, m);
      chk(alert_req, |(status.temp & ~m.temp) | |(status.comm & ~m.comm) |
        |(status.vendor & ~m.vendor));
    end
    $display("test gating done");
    wrap_up();
  end
endmodule
`default_nettype wire
